// >>> hw/ctk_pkg.sv
// How it works
// - keeps year, month, date, weekday, hour, minute, second at one-second resolution
// - core timebase unbacked; a detected backup module becomes the time source
// - battery missing over 15 s marks the stored time as lost, raising error
// - error drives green indicator and a readable status bit while present
// - error also on out-of-range (corrupt) fields or missing battery
// - seven date/time registers, readable and writable any time, write sets field
// - year register holds the full four-digit year
// - weekday runs 1 Monday through 7 Sunday
// - packed readout is hour*10000 + minute*100 + second
// - module seconds come from counting 32.768 kHz crystal periods
// - signed calibration adds or drops that many module seconds per 72 hours
// - no temperature compensation is applied anywhere
// - valid time written into an undamaged keeper clears error indicator and bit
package ctk_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_YEAR = 8'h00;
  localparam logic [7:0] OFF_MONTH = 8'h04;
  localparam logic [7:0] OFF_DATE = 8'h08;
  localparam logic [7:0] OFF_DOW = 8'h0C;
  localparam logic [7:0] OFF_HOUR = 8'h10;
  localparam logic [7:0] OFF_MIN = 8'h14;
  localparam logic [7:0] OFF_SEC = 8'h18;
  localparam logic [7:0] OFF_HMS = 8'h1C;
  localparam logic [7:0] OFF_STAT = 8'h20;
  localparam logic [7:0] OFF_CAL = 8'h24;
  localparam logic [7:0] OFF_IRQ_ST = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h2C;

  // ----------------------------------------
  // field widths and layouts
  // ----------------------------------------
  localparam int YEAR_W = 14;
  localparam int HMS_W = 18;
  localparam int CAL_W = 16;
  localparam int ACC_W = 19;
  localparam int IRQ_W = 3;
  localparam int IRQ_SEC = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_CAL = 2;
  localparam int ST_ERR = 0;
  localparam int ST_MOD = 1;
  localparam int ST_BATT = 2;
  localparam int ST_VALID = 3;
  localparam int ST_LOST = 4;

  // ----------------------------------------
  // reset values (Saturday 2000-01-01 00:00:00)
  // ----------------------------------------
  localparam logic [13:0] RST_YEAR = 14'h07D0;
  localparam logic [3:0] RST_MONTH = 4'h1;
  localparam logic [4:0] RST_DATE = 5'h01;
  localparam logic [2:0] RST_DOW = 3'h6;

  // ----------------------------------------
  // calendar limits and packing weights
  // ----------------------------------------
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [5:0] MIN_LAST = 6'h3B;
  localparam logic [4:0] HOUR_LAST = 5'h17;
  localparam logic [3:0] MONTH_LAST = 4'hC;
  localparam logic [2:0] DOW_LAST = 3'h7;
  localparam logic [17:0] HMS_HOUR_MUL = 18'h02710;
  localparam logic [17:0] HMS_MIN_MUL = 18'h00064;
  localparam logic [13:0] LEAP_4 = 14'h0004;
  localparam logic [13:0] LEAP_100 = 14'h0064;
  localparam logic [13:0] LEAP_400 = 14'h0190;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SEC_NS = 1000000000;
  localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
  localparam int XTAL_HZ = 32768;
  localparam int BATT_LOSS_S = 15;
  localparam int CAL_WINDOW_H = 72;
  localparam int CAL_WINDOW_S = CAL_WINDOW_H * 3600;

endpackage

// >>> hw/ctk_sync.sv
`timescale 1ns/1ns
module ctk_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] ff1_q;
  logic [W-1:0] ff2_q;
  logic [W-1:0] ff3_q;
  logic [W-1:0] q_q;

  // a change counts only once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1_q <= '0;
      ff2_q <= '0;
      ff3_q <= '0;
      q_q <= '0;
    end else begin
      ff1_q <= d;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      for (int i = 0; i < W; i++) begin
        if (ff2_q[i] == ff3_q[i]) begin
          q_q[i] <= ff3_q[i];
        end
      end
    end
  end

  assign q = q_q;

endmodule

// >>> hw/ctk_top.sv
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
module ctk_top #(
  parameter int SEC_CYCLES = ctk_pkg::SEC_CYCLES,
  parameter int XTAL_HZ = ctk_pkg::XTAL_HZ,
  parameter int CAL_WINDOW_S = ctk_pkg::CAL_WINDOW_S
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ctk_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic xtal_in,
  input wire logic mod_present,
  input wire logic batt_ok,
  output logic err_led,
  output logic err_flag,
  output logic irq
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pins_s;

  ctk_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({batt_ok, mod_present, xtal_in}),
    .q(pins_s)
  );

  wire xtal_s = pins_s[0];
  wire mod_s = pins_s[1];
  wire batt_s = pins_s[2];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  wire setup = psel && !penable;
  wire access = psel && penable && pready_q;
  wire wr_en = access && pwrite;
  wire hit_year = paddr == ctk_pkg::OFF_YEAR;
  wire hit_month = paddr == ctk_pkg::OFF_MONTH;
  wire hit_date = paddr == ctk_pkg::OFF_DATE;
  wire hit_dow = paddr == ctk_pkg::OFF_DOW;
  wire hit_hour = paddr == ctk_pkg::OFF_HOUR;
  wire hit_min = paddr == ctk_pkg::OFF_MIN;
  wire hit_sec = paddr == ctk_pkg::OFF_SEC;
  wire hit_hms = paddr == ctk_pkg::OFF_HMS;
  wire hit_stat = paddr == ctk_pkg::OFF_STAT;
  wire hit_cal = paddr == ctk_pkg::OFF_CAL;
  wire hit_ist = paddr == ctk_pkg::OFF_IRQ_ST;
  wire hit_imask = paddr == ctk_pkg::OFF_IRQ_MASK;
  wire hit_time = hit_year || hit_month || hit_date || hit_dow || hit_hour || hit_min
                  || hit_sec;
  wire hit_any = hit_time || hit_hms || hit_stat || hit_cal || hit_ist || hit_imask;

  // ----------------------------------------
  // calendar fields
  // ----------------------------------------
  logic [ctk_pkg::YEAR_W-1:0] year_q;
  logic [3:0] month_q;
  logic [4:0] date_q;
  logic [2:0] dow_q;
  logic [4:0] hour_q;
  logic [5:0] min_q;
  logic [5:0] sec_q;

  wire leap = (year_q % ctk_pkg::LEAP_4 == '0)
              && ((year_q % ctk_pkg::LEAP_100 != '0) || (year_q % ctk_pkg::LEAP_400 == '0));
  wire m30 = (month_q == 4'h4) || (month_q == 4'h6) || (month_q == 4'h9) || (month_q == 4'hB);
  wire [4:0] dim = (month_q == 4'h2) ? (leap ? 5'h1D : 5'h1C) : (m30 ? 5'h1E : 5'h1F);

  // >= rather than == so a corrupt field still rolls back into range
  wire sec_wrap = sec_q >= ctk_pkg::SEC_LAST;
  wire min_wrap = min_q >= ctk_pkg::MIN_LAST;
  wire hour_wrap = hour_q >= ctk_pkg::HOUR_LAST;
  wire date_wrap = date_q >= dim;
  wire month_wrap = month_q >= ctk_pkg::MONTH_LAST;
  wire c_min = sec_wrap;
  wire c_hour = c_min && min_wrap;
  wire c_day = c_hour && hour_wrap;
  wire c_month = c_day && date_wrap;
  wire c_year = c_month && month_wrap;

  wire [5:0] sec_n = sec_wrap ? 6'h00 : sec_q + 6'h01;
  wire [5:0] min_n = c_min ? (min_wrap ? 6'h00 : min_q + 6'h01) : min_q;
  wire [4:0] hour_n = c_hour ? (hour_wrap ? 5'h00 : hour_q + 5'h01) : hour_q;
  wire [4:0] date_n = c_day ? (date_wrap ? 5'h01 : date_q + 5'h01) : date_q;
  wire [3:0] month_n = c_month ? (month_wrap ? 4'h1 : month_q + 4'h1) : month_q;
  wire [ctk_pkg::YEAR_W-1:0] year_n = c_year ? year_q + 14'h0001 : year_q;
  wire [2:0] dow_n = c_day ? ((dow_q >= ctk_pkg::DOW_LAST) ? 3'h1 : dow_q + 3'h1) : dow_q;

  // out-of-range fields are taken as corrupted timekeeping data
  wire range_ok = !sec_wrap || (sec_q == ctk_pkg::SEC_LAST);
  wire fields_ok = range_ok && (min_q <= ctk_pkg::MIN_LAST) && (hour_q <= ctk_pkg::HOUR_LAST)
                   && (month_q != 4'h0) && (month_q <= ctk_pkg::MONTH_LAST)
                   && (date_q != 5'h00) && (date_q <= dim)
                   && (dow_q != 3'h0);

  // 235959 needs eighteen bits, so the sum is formed at full width
  wire [ctk_pkg::HMS_W-1:0] hms = ctk_pkg::HMS_W'(hour_q) * ctk_pkg::HMS_HOUR_MUL
                                  + ctk_pkg::HMS_W'(min_q) * ctk_pkg::HMS_MIN_MUL
                                  + ctk_pkg::HMS_W'(sec_q);

  // ----------------------------------------
  // second timebases
  // ----------------------------------------
  // no temperature correction: module drift tracks the crystal
  logic [31:0] int_cnt_q;
  logic [31:0] xt_cnt_q;
  logic xtal_d_q;

  wire int_tick = int_cnt_q == 32'(SEC_CYCLES - 1);
  wire xt_edge = xtal_s && !xtal_d_q;
  wire xt_tick = xt_edge && (xt_cnt_q == 32'(XTAL_HZ - 1));
  wire tick = mod_s ? xt_tick : int_tick;

  // ----------------------------------------
  // calibration over the 72 hour window
  // ----------------------------------------
  logic [ctk_pkg::CAL_W-1:0] cal_q;
  logic [ctk_pkg::ACC_W-1:0] acc_q;
  logic extra_q;

  wire cal_neg = cal_q[ctk_pkg::CAL_W-1];
  wire [ctk_pkg::CAL_W-1:0] cal_mag = cal_neg ? (~cal_q + 16'h0001) : cal_q;
  wire [ctk_pkg::ACC_W-1:0] acc_sum = acc_q + ctk_pkg::ACC_W'(cal_mag);
  wire cal_fire = mod_s && tick && (acc_sum >= ctk_pkg::ACC_W'(CAL_WINDOW_S));
  wire [ctk_pkg::ACC_W-1:0] acc_n = cal_fire ? acc_sum - ctk_pkg::ACC_W'(CAL_WINDOW_S)
                                             : acc_sum;

  // a negative correction swallows a tick, a positive one adds a step next cycle
  wire step_req = (tick && !(cal_fire && cal_neg)) || extra_q;

  // steps wait out a register write so software never races the carry chain
  logic [1:0] pend_q;
  wire do_step = (pend_q != 2'h0) && !wr_en;
  wire [1:0] pend_n = pend_q + {1'b0, step_req} - {1'b0, do_step};

  // ----------------------------------------
  // validity and error
  // ----------------------------------------
  logic valid_q;
  logic lost_q;
  logic [4:0] absent_q;
  logic err_q;
  logic err_d_q;

  wire batt_missing = mod_s && !batt_s;
  wire absent_over = absent_q > 5'(ctk_pkg::BATT_LOSS_S);
  wire err = !valid_q || lost_q || !fields_ok || batt_missing;

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  logic [ctk_pkg::IRQ_W-1:0] ist_q;
  logic [ctk_pkg::IRQ_W-1:0] imask_q;
  logic irq_q;

  wire [ctk_pkg::IRQ_W-1:0] ev = {cal_fire, err && !err_d_q, do_step};
  wire [ctk_pkg::IRQ_W-1:0] ist_clr = (wr_en && hit_ist) ? pwdata[ctk_pkg::IRQ_W-1:0] : '0;
  // set wins over a clear landing in the same cycle
  wire [ctk_pkg::IRQ_W-1:0] ist_n = (ist_q & ~ist_clr) | ev;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [31:0] stat_w = {27'h0000000, lost_q, valid_q, batt_s, mod_s, err_q};
  wire [31:0] rd_mux = hit_year ? 32'(year_q) :
                       hit_month ? 32'(month_q) :
                       hit_date ? 32'(date_q) :
                       hit_dow ? 32'(dow_q) :
                       hit_hour ? 32'(hour_q) :
                       hit_min ? 32'(min_q) :
                       hit_sec ? 32'(sec_q) :
                       hit_hms ? 32'(hms) :
                       hit_stat ? stat_w :
                       hit_cal ? {{16{cal_q[ctk_pkg::CAL_W-1]}}, cal_q} :
                       hit_ist ? 32'(ist_q) :
                       hit_imask ? 32'(imask_q) : 32'h00000000;

  // ----------------------------------------
  // apb handshake: zero wait, answer registered in setup
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !hit_any;
      prdata_q <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------
  // calendar registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      year_q <= ctk_pkg::RST_YEAR;
      month_q <= ctk_pkg::RST_MONTH;
      date_q <= ctk_pkg::RST_DATE;
      dow_q <= ctk_pkg::RST_DOW;
      hour_q <= '0;
      min_q <= '0;
      sec_q <= '0;
    end else if (wr_en && hit_time) begin
      if (hit_year) year_q <= pwdata[ctk_pkg::YEAR_W-1:0];
      if (hit_month) month_q <= pwdata[3:0];
      if (hit_date) date_q <= pwdata[4:0];
      if (hit_dow) dow_q <= pwdata[2:0];
      if (hit_hour) hour_q <= pwdata[4:0];
      if (hit_min) min_q <= pwdata[5:0];
      if (hit_sec) sec_q <= pwdata[5:0];
    end else if (do_step) begin
      year_q <= year_n;
      month_q <= month_n;
      date_q <= date_n;
      dow_q <= dow_n;
      hour_q <= hour_n;
      min_q <= min_n;
      sec_q <= sec_n;
    end
  end

  // ----------------------------------------
  // timebase and calibration state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cnt_q <= '0;
      xt_cnt_q <= '0;
      xtal_d_q <= 1'b0;
      cal_q <= '0;
      acc_q <= '0;
      extra_q <= 1'b0;
      pend_q <= 2'h0;
    end else begin
      int_cnt_q <= int_tick ? '0 : int_cnt_q + 32'h00000001;
      xtal_d_q <= xtal_s;
      if (xt_edge) xt_cnt_q <= xt_tick ? '0 : xt_cnt_q + 32'h00000001;
      if (wr_en && hit_cal) cal_q <= pwdata[ctk_pkg::CAL_W-1:0];
      if (tick && mod_s) acc_q <= acc_n;
      extra_q <= cal_fire && !cal_neg;
      pend_q <= pend_n;
    end
  end

  // ----------------------------------------
  // validity, loss and error outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= 1'b0;
      lost_q <= 1'b0;
      absent_q <= '0;
      err_q <= 1'b1;
      err_d_q <= 1'b1;
    end else begin
      if (!batt_missing) absent_q <= '0;
      else if (int_tick && !absent_over) absent_q <= absent_q + 5'h01;
      if (absent_over) lost_q <= 1'b1;
      else if (wr_en && hit_time) lost_q <= 1'b0;
      if (absent_over) valid_q <= 1'b0;
      else if (wr_en && hit_time) valid_q <= 1'b1;
      err_q <= err;
      err_d_q <= err_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
      imask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ist_q <= ist_n;
      if (wr_en && hit_imask) imask_q <= pwdata[ctk_pkg::IRQ_W-1:0];
      irq_q <= |(ist_n & imask_q);
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign err_led = err_q;
  assign err_flag = err_q;
  assign irq = irq_q;

endmodule

// >>> test/ctk_asserts.sv
`timescale 1ns/1ns
module ctk_chk #(
  parameter int SEC_CYCLES = 10,
  parameter int XTAL_HZ = 4,
  parameter int CAL_WINDOW_S = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ctk_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic err_led,
  input wire logic err_flag,
  input wire logic irq
);
  // ----------------------------------------
  // bus and error relations
  // ----------------------------------------
  wire done = psel && penable && pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_in_access_a: assert property (pready |-> psel && penable && !$past(pready))
    else $error("answer outside access");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  slverr_with_ready_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
  led_matches_flag_a: assert property (err_led == err_flag)
    else $error("indicator and flag differ");
  bad_month_err_a: assert property (done && pwrite && paddr == ctk_pkg::OFF_MONTH &&
    pwdata == 32'hD |-> ##[1:3] err_flag) else $error("corrupt month not flagged");
  hms_range_a: assert property (done && !pwrite && paddr == ctk_pkg::OFF_HMS
    |-> prdata <= 32'h000399B7) else $error("packed time out of range");
  mask_off_irq_a: assert property (done && pwrite && paddr == ctk_pkg::OFF_IRQ_MASK &&
    pwdata[2:0] == 3'h0 |-> ##2 !irq) else $error("irq high with empty mask");
  reset_err_a: assert property ($rose(presetn) |-> err_flag)
    else $error("time valid right after reset");
  dow_range_a: assert property (done && !pwrite && paddr == ctk_pkg::OFF_DOW
    |-> prdata inside {[1:7]}) else $error("weekday out of range");
endmodule
bind ctk_top ctk_chk #(.SEC_CYCLES(SEC_CYCLES), .XTAL_HZ(XTAL_HZ), .CAL_WINDOW_S(CAL_WINDOW_S))
  u_ctk_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .err_led(err_led), .err_flag(err_flag), .irq(irq));

// >>> test/ctk_top_tb.sv
`timescale 1ns/1ns
module ctk_top_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rng = 32'h7F48;
  logic pready, pslverr, err_led, err_flag, irq;
  logic xtal_in = 1'b0, mod_present = 1'b1, batt_ok = 1'b1;
  logic [33:0] notes[$];
  logic [33:0] nt;
  int miscompares = 0, checked = 0, h, m, s;
  int cs[3][7] = '{'{2023, 12, 31, 7, 23, 59, 59}, '{2024, 2, 28, 3, 23, 59, 59},
    '{2023, 2, 28, 2, 23, 59, 59}};
  int ce[3][8] = '{'{2024, 1, 1, 1, 0, 0, 0, 0}, '{2024, 2, 29, 4, 0, 0, 0, 0},
    '{2023, 3, 1, 3, 0, 0, 0, 0}};
  always #2 pclk = ~pclk;
  ctk_top #(.SEC_CYCLES(10), .XTAL_HZ(4), .CAL_WINDOW_S(20)) u_ctk_top (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .xtal_in(xtal_in),
    .mod_present(mod_present), .batt_ok(batt_ok), .err_led(err_led), .err_flag(err_flag),
    .irq(irq));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk_pin(input string name, input logic exp, input logic seen);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task chk_bus(input logic [33:0] x, input logic e, input logic [31:0] d);
    checked++;
    if (e !== x[32] || (x[33] && d !== x[31:0])) begin
      miscompares++;
      $display("[ERR] bus expected %b/%h seen %b/%h", x[32], x[31:0], e, d);
    end
  endtask
  always @(posedge pclk) begin
    if (presetn === 1'b1 && pready === 1'b1) begin
      nt = (notes.size() > 0) ? notes.pop_front() : 34'h3FFFFFFFF;
      chk_bus(nt, pslverr, prdata);
    end
  end
  // one apb transfer; the expected answer is noted before the request goes out
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
    int n;
    notes.push_back(x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d, {1'b0, e, 32'h0});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b1, 1'b0, x});
  endtask
  // crystal idles between bursts, so with the module present time only moves when stepped here
  task xsec(input int n);
    repeat (4 * n) begin
      @(posedge pclk) xtal_in <= 1'b1;
      repeat (3) @(posedge pclk);
      xtal_in <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk_pin("err_flag", 1'b1, err_flag);
    rd(ctk_pkg::OFF_STAT, 32'h7);
    rd(ctk_pkg::OFF_YEAR, 32'h7D0);
    rd(ctk_pkg::OFF_DOW, 32'h6);
    $display("reset test done");
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 7; i++) wr(8'(4 * i), 32'(cs[c][i]), 1'b0);
      repeat (4) @(posedge pclk);
      chk_pin("err_flag", 1'b0, err_flag);
      xsec(1);
      for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'(ce[c][i]));
    end
    $display("rollover test done");
    for (int k = 0; k < 5; k++) begin
      rng = lfsr_next(rng);
      h = (k == 4) ? 1 : int'(rng % 24);
      m = (k == 4) ? 0 : int'((rng >> 8) % 60);
      s = (k == 4) ? 15 : int'((rng >> 16) % 60);
      wr(ctk_pkg::OFF_HOUR, 32'(h), 1'b0);
      wr(ctk_pkg::OFF_MIN, 32'(m), 1'b0);
      wr(ctk_pkg::OFF_SEC, 32'(s), 1'b0);
      rd(ctk_pkg::OFF_MIN, 32'(m));
      rd(ctk_pkg::OFF_HMS, 32'(h * 10000 + m * 100 + s));
    end
    wr(ctk_pkg::OFF_HMS, 32'h1234, 1'b0);
    rd(ctk_pkg::OFF_HMS, 32'(10015));
    wr(8'h30, 32'h5, 1'b1);
    apb(1'b0, 8'h30, 32'h0, {1'b1, 1'b1, 32'h0});
    $display("packed time test done");
    wr(ctk_pkg::OFF_CAL, 32'(20), 1'b0);
    wr(ctk_pkg::OFF_SEC, 32'h0, 1'b0);
    xsec(2);
    rd(ctk_pkg::OFF_SEC, 32'h4);
    wr(ctk_pkg::OFF_CAL, 32'hFFFFFFEC, 1'b0);
    rd(ctk_pkg::OFF_CAL, 32'hFFFFFFEC);
    wr(ctk_pkg::OFF_SEC, 32'hA, 1'b0);
    xsec(2);
    rd(ctk_pkg::OFF_SEC, 32'hA);
    wr(ctk_pkg::OFF_CAL, 32'h0, 1'b0);
    xsec(3);
    rd(ctk_pkg::OFF_SEC, 32'hD);
    $display("calibration test done");
    wr(ctk_pkg::OFF_IRQ_ST, 32'h7, 1'b0);
    wr(ctk_pkg::OFF_IRQ_MASK, 32'h2, 1'b0);
    wr(ctk_pkg::OFF_MONTH, 32'hD, 1'b0);
    repeat (4) @(posedge pclk);
    chk_pin("err_flag", 1'b1, err_flag);
    chk_pin("irq", 1'b1, irq);
    rd(ctk_pkg::OFF_STAT, 32'hF);
    wr(ctk_pkg::OFF_IRQ_ST, 32'h2, 1'b0);
    repeat (4) @(posedge pclk);
    chk_pin("irq", 1'b0, irq);
    wr(ctk_pkg::OFF_MONTH, 32'hC, 1'b0);
    wr(ctk_pkg::OFF_IRQ_MASK, 32'h0, 1'b0);
    repeat (4) @(posedge pclk);
    chk_pin("err_flag", 1'b0, err_flag);
    @(posedge pclk) batt_ok <= 1'b0;
    repeat (10) @(posedge pclk);
    chk_pin("err_flag", 1'b1, err_flag);
    chk_pin("irq", 1'b0, irq);
    rd(ctk_pkg::OFF_STAT, 32'hB);
    @(posedge pclk) batt_ok <= 1'b1;
    repeat (10) @(posedge pclk);
    chk_pin("err_flag", 1'b0, err_flag);
    $display("error test done");
    @(posedge pclk) batt_ok <= 1'b0;
    repeat (200) @(posedge pclk);
    batt_ok <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(ctk_pkg::OFF_STAT, 32'h17);
    chk_pin("err_led", 1'b1, err_led);
    wr(ctk_pkg::OFF_SEC, 32'h0, 1'b0);
    repeat (4) @(posedge pclk);
    chk_pin("err_led", 1'b0, err_led);
    $display("loss test done");
    wr(ctk_pkg::OFF_IRQ_ST, 32'h7, 1'b0);
    wr(ctk_pkg::OFF_IRQ_MASK, 32'h1, 1'b0);
    repeat (30) @(posedge pclk);
    chk_pin("irq", 1'b0, irq);
    mod_present <= 1'b0;
    repeat (30) @(posedge pclk);
    chk_pin("irq", 1'b1, irq);
    rd(ctk_pkg::OFF_STAT, 32'hC);
    $display("timebase test done");
    for (int n = 0; n < 50 && notes.size() > 0; n++) @(posedge pclk);
    if (notes.size() > 0) miscompares++;
    give_verdict();
  end
endmodule
